// >>> inc/alarm_wake_pkg.sv
`default_nettype none

package alarm_wake_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 16;
    localparam int WAKE_SRC_W = 15;
    localparam int ALARM_SRC_W = 3;
    localparam int IRQ_W = 3;

    typedef logic [ADDR_W-1:0] addr_t;
    typedef logic [DATA_W-1:0] data_t;

    localparam addr_t ALARM_ENABLE_UPPER_OFS = 12'h403;
    localparam addr_t ALARM_REASON_UPPER_OFS = 12'h405;
    localparam addr_t WAKE_ENABLE_LOWER_OFS = 12'h408;
    localparam addr_t WAKE_REASON_LOWER_OFS = 12'h40A;
    localparam addr_t IRQ_STATUS_OFS = 12'h4F0;
    localparam addr_t IRQ_MASK_OFS = 12'h4F1;
    localparam addr_t SLEEP_CTRL_OFS = 12'h4F2;
    localparam addr_t EVENT_LEVEL_OFS = 12'h4F3;

    // alarm reason and alarm enable layout
    localparam int BAL_PROT_BIT = 8;
    localparam int ABS_UNDER_BIT = 1;
    localparam int ABS_OVER_BIT = 0;

    // wake enable and wake reason layout
    localparam int CHAIN_FRAME_BIT = 15;
    localparam int LINK_REASON_BIT = 15;
    localparam int FAULT_BIT = 14;
    localparam int BAL_DONE_BIT = 13;
    localparam int WAKE_PIN_BIT = 12;
    localparam int ALARM_PIN_BIT = 11;
    localparam int ANALOG_HI_BIT = 10;
    localparam int ANALOG_LO_BIT = 3;
    localparam int CELL_UV_HI_BIT = 2;
    localparam int CELL_UV_LO_BIT = 1;
    localparam int CELL_OV_BIT = 0;

    localparam int SLEEP_REQ_BIT = 0;
    localparam int IRQ_ALARM_BIT = 0;
    localparam int IRQ_WAKE_BIT = 1;
    localparam int IRQ_FRAME_BIT = 2;

    localparam data_t WAKE_ENABLE_RESET = 16'h0000;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;
    localparam data_t READ_IDLE = 16'h0000;

    typedef struct packed {
        addr_t addr;
        data_t wdata;
        logic wr;
        logic rd;
    } bus_req_s;

    typedef struct packed {
        logic balance_protection_event;
        logic absolute_input_under_event;
        logic absolute_input_over_event;
    } alarm_events_s;

    localparam alarm_events_s ALARM_ENABLE_RESET = 3'h0;

    typedef struct packed {
        logic system_fault_event;
        logic balancing_done_event;
        logic wake_pin_event;
        logic alarm_pin_event;
        logic analog3_under_event;
        logic analog3_over_event;
        logic analog2_under_event;
        logic analog2_over_event;
        logic analog1_under_event;
        logic analog1_over_event;
        logic analog0_under_event;
        logic analog0_over_event;
        logic cell_under_second_event;
        logic cell_under_first_event;
        logic cell_over_event;
    } wake_events_s;

    typedef enum logic {
        ST_AWAKE,
        ST_ASLEEP
    } power_state_e;

    function automatic logic reg_hit(addr_t addr, addr_t ofs);
        return addr == ofs;
    endfunction

    function automatic data_t alarm_word(alarm_events_s v);
        data_t w;
        w = READ_IDLE;
        w[BAL_PROT_BIT] = v.balance_protection_event;
        w[ABS_UNDER_BIT] = v.absolute_input_under_event;
        w[ABS_OVER_BIT] = v.absolute_input_over_event;
        return w;
    endfunction

    function automatic alarm_events_s alarm_bits(data_t w);
        alarm_events_s v;
        v.balance_protection_event = w[BAL_PROT_BIT];
        v.absolute_input_under_event = w[ABS_UNDER_BIT];
        v.absolute_input_over_event = w[ABS_OVER_BIT];
        return v;
    endfunction

endpackage

`default_nettype wire

// >>> rtl/sticky_flags.sv
`timescale 1ns/1ps
`default_nettype none

module sticky_flags #(
    parameter int W = 1
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [W-1:0] set,
    input wire logic clear,
    output logic [W-1:0] flags_q
);

    logic [W-1:0] flags_d;

    // an event in the clearing cycle survives the read
    assign flags_d = (flags_q & ~{W{clear}}) | set; // [R15]

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            flags_q <= '0;
        end else begin
            flags_q <= flags_d;
        end
    end

endmodule

`default_nettype wire

// >>> rtl/event_edge.sv
`timescale 1ns/1ps
`default_nettype none

module event_edge #(
    parameter int W = 1
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [W-1:0] level,
    output logic [W-1:0] rise
);

    logic [W-1:0] level_q;

    // detectors hold their level; only a fresh assertion counts
    assign rise = level & ~level_q;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            level_q <= '0;
        end else begin
            level_q <= level;
        end
    end

endmodule

`default_nettype wire

// >>> rtl/alarm_wake_ctrl.sv
// Behaviour
// [R1] balancing protection alarm latches reason bit 8
// [R2] absolute input undervoltage alarm latches bit 1
// [R3] absolute input overvoltage alarm latches bit 0
// [R4] reserved reason bits read zero, ignore writes
// [R5] bit 15 sends chain frame unless link
// [R6] bit 14 lets system fault wake
// [R7] bit 13 lets balancing done wake
// [R8] bit 12 wakes on pin, enables receiver
// [R9] bit 11 lets alarm pin wake
// [R10] bits 10 to 3 enable analog threshold wakes
// [R11] bits 2 and 1 enable cell undervoltage wakes
// [R12] bit 0 enables cell overvoltage wake
// [R13] alarm enable gates each reason latch
// [R14] link wake kept in read-clear flag
// [R15] set beats read clear in same cycle
// [R16] only enabled events or link activity end sleep
//
// Design decision made here: the address-and-strobe port.

`timescale 1ns/1ps
`default_nettype none

module alarm_wake_ctrl (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire alarm_wake_pkg::bus_req_s bus_req,
    output var alarm_wake_pkg::data_t rdata_q,
    input wire alarm_wake_pkg::alarm_events_s alarm_events,
    input wire alarm_wake_pkg::wake_events_s wake_events,
    input wire logic link_activity_wake,
    output logic alarm_out_q,
    output logic awake_q,
    output logic chain_wake_frame_q,
    output logic wake_rx_enable_q,
    output logic irq_q
);

    import alarm_wake_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // register decode

    logic hit_alarm_enable;
    logic hit_alarm_reason;
    logic hit_wake_enable;
    logic hit_wake_reason;
    logic hit_irq_status;
    logic hit_irq_mask;
    logic hit_sleep_ctrl;
    logic hit_event_level;

    assign hit_alarm_enable = reg_hit(bus_req.addr, ALARM_ENABLE_UPPER_OFS);
    assign hit_alarm_reason = reg_hit(bus_req.addr, ALARM_REASON_UPPER_OFS);
    assign hit_wake_enable = reg_hit(bus_req.addr, WAKE_ENABLE_LOWER_OFS);
    assign hit_wake_reason = reg_hit(bus_req.addr, WAKE_REASON_LOWER_OFS);
    assign hit_irq_status = reg_hit(bus_req.addr, IRQ_STATUS_OFS);
    assign hit_irq_mask = reg_hit(bus_req.addr, IRQ_MASK_OFS);
    assign hit_sleep_ctrl = reg_hit(bus_req.addr, SLEEP_CTRL_OFS);
    assign hit_event_level = reg_hit(bus_req.addr, EVENT_LEVEL_OFS);

    logic wr_alarm_enable;
    logic wr_wake_enable;
    logic wr_irq_mask;
    logic wr_sleep_ctrl;
    logic rd_alarm_reason;
    logic rd_wake_reason;
    logic rd_irq_status;

    // writes to the reason and status registers have no effect
    assign wr_alarm_enable = bus_req.wr & hit_alarm_enable;
    assign wr_wake_enable = bus_req.wr & hit_wake_enable;
    assign wr_irq_mask = bus_req.wr & hit_irq_mask;
    assign wr_sleep_ctrl = bus_req.wr & hit_sleep_ctrl;
    assign rd_alarm_reason = bus_req.rd & hit_alarm_reason;
    assign rd_wake_reason = bus_req.rd & hit_wake_reason;
    assign rd_irq_status = bus_req.rd & hit_irq_status;

    ////////////////////////////////////////////////////////////////////////
    // event edges

    // a level already high when reset lifts counts as a fresh rise
    logic [ALARM_SRC_W+WAKE_SRC_W-1:0] ev_rise;
    alarm_events_s alarm_rise;
    logic [WAKE_SRC_W-1:0] wake_rise;

    event_edge #(
        .W(ALARM_SRC_W + WAKE_SRC_W)
    ) u_event_edge (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .level({alarm_events, wake_events}),
        .rise(ev_rise)
    );

    assign alarm_rise = ev_rise[ALARM_SRC_W+WAKE_SRC_W-1:WAKE_SRC_W];
    assign wake_rise = ev_rise[WAKE_SRC_W-1:0];

    ////////////////////////////////////////////////////////////////////////
    // alarm enable and alarm reason

    alarm_events_s alarm_en_q;
    alarm_events_s alarm_en_d;
    alarm_events_s alarm_set;
    alarm_events_s alarm_reason;

    assign alarm_en_d = wr_alarm_enable ? alarm_bits(bus_req.wdata)
                                        : alarm_en_q;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            alarm_en_q <= ALARM_ENABLE_RESET;
        end else begin
            alarm_en_q <= alarm_en_d;
        end
    end

    // a source that is not enabled for the alarm never latches a reason
    assign alarm_set.balance_protection_event =
        alarm_rise.balance_protection_event &
        alarm_en_q.balance_protection_event; // [R1] [R13]
    assign alarm_set.absolute_input_under_event =
        alarm_rise.absolute_input_under_event &
        alarm_en_q.absolute_input_under_event; // [R2] [R13]
    assign alarm_set.absolute_input_over_event =
        alarm_rise.absolute_input_over_event &
        alarm_en_q.absolute_input_over_event; // [R3] [R13]

    sticky_flags #(
        .W(ALARM_SRC_W)
    ) u_alarm_reason (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .set(alarm_set),
        .clear(rd_alarm_reason),
        .flags_q(alarm_reason)
    );

    ////////////////////////////////////////////////////////////////////////
    // wake source enable

    data_t wake_enable_q;
    data_t wake_enable_d;
    logic [WAKE_SRC_W-1:0] wake_en;
    logic [WAKE_SRC_W-1:0] wake_hits;

    assign wake_enable_d = wr_wake_enable ? bus_req.wdata : wake_enable_q;
    // bit 15 is stored beside the sources but never wakes by itself
    assign wake_en = wake_enable_q[WAKE_SRC_W-1:0];

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            wake_enable_q <= WAKE_ENABLE_RESET;
        end else begin
            wake_enable_q <= wake_enable_d;
        end
    end

    assign wake_hits[FAULT_BIT] =
        wake_rise[FAULT_BIT] & wake_en[FAULT_BIT]; // [R6]
    assign wake_hits[BAL_DONE_BIT] =
        wake_rise[BAL_DONE_BIT] & wake_en[BAL_DONE_BIT]; // [R7]
    assign wake_hits[WAKE_PIN_BIT] =
        wake_rise[WAKE_PIN_BIT] & wake_en[WAKE_PIN_BIT]; // [R8]
    assign wake_hits[ALARM_PIN_BIT] =
        wake_rise[ALARM_PIN_BIT] & wake_en[ALARM_PIN_BIT]; // [R9]
    assign wake_hits[ANALOG_HI_BIT:ANALOG_LO_BIT] =
        wake_rise[ANALOG_HI_BIT:ANALOG_LO_BIT] &
        wake_en[ANALOG_HI_BIT:ANALOG_LO_BIT]; // [R10]
    assign wake_hits[CELL_UV_HI_BIT:CELL_UV_LO_BIT] =
        wake_rise[CELL_UV_HI_BIT:CELL_UV_LO_BIT] &
        wake_en[CELL_UV_HI_BIT:CELL_UV_LO_BIT]; // [R11]
    assign wake_hits[CELL_OV_BIT] =
        wake_rise[CELL_OV_BIT] & wake_en[CELL_OV_BIT]; // [R12]

    ////////////////////////////////////////////////////////////////////////
    // sleep and wake sequencing

    power_state_e state_q;
    power_state_e state_d;
    logic sleep_req;
    logic wake_now;
    logic waking;
    logic frame_d;
    logic asleep;

    // a sleep request while asleep changes nothing
    assign sleep_req = wr_sleep_ctrl & bus_req.wdata[SLEEP_REQ_BIT];
    // link activity always wakes; other sources only when enabled
    assign wake_now = (|wake_hits) | link_activity_wake; // [R16]
    assign asleep = state_q == ST_ASLEEP;
    assign waking = asleep & wake_now;

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_AWAKE: begin
                if (sleep_req) begin
                    state_d = ST_ASLEEP;
                end
            end
            ST_ASLEEP: begin
                if (wake_now) begin
                    state_d = ST_AWAKE; // [R16]
                end
            end
            default: begin
                state_d = ST_AWAKE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= ST_AWAKE;
        end else begin
            state_q <= state_d;
        end
    end

    // no frame when the chain itself woke us: the others are awake already
    assign frame_d = waking & wake_enable_q[CHAIN_FRAME_BIT] &
                     ~link_activity_wake; // [R5] [R14]

    ////////////////////////////////////////////////////////////////////////
    // wake reason

    data_t wake_reason_set;
    data_t wake_reason;

    // causes are recorded only on the edge that ends sleep
    assign wake_reason_set[LINK_REASON_BIT] =
        waking & link_activity_wake; // [R14]
    assign wake_reason_set[WAKE_SRC_W-1:0] =
        wake_hits & {WAKE_SRC_W{waking}};

    sticky_flags #(
        .W(DATA_W)
    ) u_wake_reason (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .set(wake_reason_set),
        .clear(rd_wake_reason),
        .flags_q(wake_reason)
    );

    ////////////////////////////////////////////////////////////////////////
    // interrupt status and mask

    logic [IRQ_W-1:0] irq_set;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask_q;
    logic [IRQ_W-1:0] irq_mask_d;

    // alarm latches, wake-ups and frames are kept apart for software
    assign irq_set[IRQ_ALARM_BIT] = |alarm_set;
    assign irq_set[IRQ_WAKE_BIT] = waking;
    assign irq_set[IRQ_FRAME_BIT] = frame_d;

    sticky_flags #(
        .W(IRQ_W)
    ) u_irq_status (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .set(irq_set),
        .clear(rd_irq_status),
        .flags_q(irq_status)
    );

    assign irq_mask_d = wr_irq_mask ? bus_req.wdata[IRQ_W-1:0] : irq_mask_q;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_mask_q <= IRQ_MASK_RESET;
        end else begin
            irq_mask_q <= irq_mask_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data

    data_t rdata_d;
    data_t rd_sel;

    // reserved reason bits are never stored, so they read as zero
    assign rd_sel =
        ({DATA_W{hit_alarm_enable}} & alarm_word(alarm_en_q)) |
        ({DATA_W{hit_alarm_reason}} & alarm_word(alarm_reason)) | // [R4]
        ({DATA_W{hit_wake_enable}} & wake_enable_q) |
        ({DATA_W{hit_wake_reason}} & wake_reason) |
        ({DATA_W{hit_irq_status}} & data_t'(irq_status)) |
        ({DATA_W{hit_irq_mask}} & data_t'(irq_mask_q)) |
        ({DATA_W{hit_sleep_ctrl}} & data_t'(asleep)) |
        ({DATA_W{hit_event_level}} & data_t'(wake_events));

    // data stand for one cycle only; unmapped reads return zero
    // a clearing read returns the flags as they stood before the clear
    assign rdata_d = bus_req.rd ? rd_sel : READ_IDLE;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_q <= READ_IDLE;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registered outputs

    logic alarm_out_d;
    logic irq_d;

    // re-registered so no pin sees decode glitches, at one cycle's cost
    assign alarm_out_d = |alarm_reason;
    assign irq_d = |(irq_status & irq_mask_q);

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            alarm_out_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            alarm_out_q <= alarm_out_d;
            irq_q <= irq_d;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            awake_q <= 1'b1;
            chain_wake_frame_q <= 1'b0;
            wake_rx_enable_q <= 1'b0;
        end else begin
            awake_q <= state_d == ST_AWAKE;
            chain_wake_frame_q <= frame_d; // [R5]
            wake_rx_enable_q <= wake_enable_d[WAKE_PIN_BIT]; // [R8]
        end
    end

endmodule

`default_nettype wire

// >>> dv/alarm_wake_checker.sv
`timescale 1ns/1ps
`default_nettype none

module alarm_wake_checker (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire alarm_wake_pkg::bus_req_s bus_req,
    input wire alarm_wake_pkg::data_t rdata_q,
    input wire alarm_wake_pkg::alarm_events_s alarm_events,
    input wire alarm_wake_pkg::wake_events_s wake_events,
    input wire logic link_activity_wake,
    input wire logic alarm_out_q,
    input wire logic awake_q,
    input wire logic chain_wake_frame_q,
    input wire logic wake_rx_enable_q,
    input wire logic irq_q
);
    import alarm_wake_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    // reserved reason bits 15:9 and 7:2
    localparam data_t RSVD = 16'hFEFC;
    logic cfg_wr;
    assign cfg_wr = bus_req.wr && bus_req.addr == WAKE_ENABLE_LOWER_OFS;

    ////////////////////////////////////////////////////////////////////////
    sequence s_sleep_req;
        bus_req.wr && bus_req.addr == SLEEP_CTRL_OFS &&
            bus_req.wdata[SLEEP_REQ_BIT];
    endsequence
    sequence s_reason_rd;
        bus_req.rd && bus_req.addr == ALARM_REASON_UPPER_OFS;
    endsequence

    property p_read_zero;
        rdata_q != READ_IDLE |-> $past(bus_req.rd);
    endproperty
    property p_reserved;
        s_reason_rd |=> (rdata_q & RSVD) == READ_IDLE;
    endproperty
    property p_rx_follow;
        cfg_wr |=> wake_rx_enable_q == $past(bus_req.wdata[WAKE_PIN_BIT]);
    endproperty
    property p_rx_hold;
        !cfg_wr |=> $stable(wake_rx_enable_q);
    endproperty
    property p_sleep;
        s_sleep_req |=> !awake_q;
    endproperty
    property p_wake_cause;
        $rose(awake_q) |-> $past(link_activity_wake || wake_events != '0);
    endproperty
    property p_frame_cause;
        chain_wake_frame_q |->
            awake_q && !$past(awake_q) && !$past(link_activity_wake);
    endproperty
    property p_frame_pulse;
        chain_wake_frame_q |=> !chain_wake_frame_q;
    endproperty
    // flag lands one edge after the rise, the output one edge later
    property p_alarm_rise;
        $rose(alarm_out_q) |-> $past(alarm_events, 2) != '0;
    endproperty
    property p_alarm_fall;
        $fell(alarm_out_q) |-> $past(bus_req.rd &&
            bus_req.addr == ALARM_REASON_UPPER_OFS, 2);
    endproperty

    ////////////////////////////////////////////////////////////////////////
    a_read_zero: assert property (p_read_zero)
        else $error("stray rdata");
    a_reserved: assert property (p_reserved)
        else $error("reserved set");
    a_rx_follow: assert property (p_rx_follow)
        else $error("rx enable");
    a_rx_hold: assert property (p_rx_hold)
        else $error("rx enable moved");
    a_sleep: assert property (p_sleep)
        else $error("no sleep");
    a_wake_cause: assert property (p_wake_cause)
        else $error("bad wake");
    a_frame_cause: assert property (p_frame_cause)
        else $error("frame cause");
    a_frame_pulse: assert property (p_frame_pulse)
        else $error("frame pulse");
    a_alarm_rise: assert property (p_alarm_rise)
        else $error("alarm rise");
    a_alarm_fall: assert property (p_alarm_fall)
        else $error("alarm fall");
endmodule

bind alarm_wake_ctrl alarm_wake_checker u_alarm_wake_checker (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .bus_req(bus_req),
    .rdata_q(rdata_q),
    .alarm_events(alarm_events),
    .wake_events(wake_events),
    .link_activity_wake(link_activity_wake),
    .alarm_out_q(alarm_out_q),
    .awake_q(awake_q),
    .chain_wake_frame_q(chain_wake_frame_q),
    .wake_rx_enable_q(wake_rx_enable_q),
    .irq_q(irq_q)
);

`default_nettype wire

// >>> dv/alarm_wake_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none

module alarm_wake_ctrl_tb;
    import alarm_wake_pkg::*;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    bus_req_s req = '0;
    alarm_events_s alarm_ev = '0;
    wake_events_s wake_ev = '0;
    logic link = 1'b0;
    data_t rdata_q;
    logic alarm_out_q, awake_q, chain_wake_frame_q, wake_rx_enable_q, irq_q;
    int fail_count = 0;
    int checked = 0;
    int frames = 0;

    always #25 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        if (chain_wake_frame_q === 1'b1) begin
            frames <= frames + 1;
        end
    end

    alarm_wake_ctrl u_alarm_wake_ctrl (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .bus_req(req),
        .rdata_q(rdata_q),
        .alarm_events(alarm_ev),
        .wake_events(wake_ev),
        .link_activity_wake(link),
        .alarm_out_q(alarm_out_q),
        .awake_q(awake_q),
        .chain_wake_frame_q(chain_wake_frame_q),
        .wake_rx_enable_q(wake_rx_enable_q),
        .irq_q(irq_q)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic compare(input string what, input data_t seen,
                           input data_t exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // ends 1 ns past the edge so outputs have settled
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic reg_wr(input addr_t a, input data_t d);
        @(posedge core_clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        req.wr <= 1'b0;
        #1;
    endtask

    task automatic reg_rd(input addr_t a, input data_t exp);
        @(posedge core_clk);
        req <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        req.rd <= 1'b0;
        #1;
        compare("rdata", rdata_q, exp);
    endtask

    // one-cycle level so each source gives exactly one rise
    task automatic raise(input alarm_events_s a, input wake_events_s w,
                         input logic l);
        @(posedge core_clk);
        alarm_ev <= a;
        wake_ev <= w;
        link <= l;
        @(posedge core_clk);
        alarm_ev <= '0;
        wake_ev <= '0;
        link <= 1'b0;
        tick(3);
    endtask

    task automatic results();
        if (fail_count == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        #1000000;
        fail_count++;
        results();
    end

    initial begin
        repeat (20) @(posedge core_clk);
        arst_n <= 1'b1;
        tick(1);
        compare("awake", data_t'(awake_q), 16'h0001);
        compare("rx_en", data_t'(wake_rx_enable_q), 16'h0000);
        reg_rd(ALARM_REASON_UPPER_OFS, 16'h0000);
        reg_rd(WAKE_ENABLE_LOWER_OFS, 16'h0000);
        reg_rd(12'h7FF, 16'h0000);
        reg_wr(WAKE_ENABLE_LOWER_OFS, 16'hFFFF);
        compare("rx_en", data_t'(wake_rx_enable_q), 16'h0001);
        reg_rd(WAKE_ENABLE_LOWER_OFS, 16'hFFFF);
        reg_wr(WAKE_ENABLE_LOWER_OFS, 16'hEFFF);
        compare("rx_en", data_t'(wake_rx_enable_q), 16'h0000);
        reg_wr(ALARM_REASON_UPPER_OFS, 16'hFFFF);
        reg_rd(ALARM_REASON_UPPER_OFS, 16'h0000);
        reg_wr(IRQ_MASK_OFS, 16'h0001);
        reg_rd(IRQ_MASK_OFS, 16'h0001);
        reg_wr(ALARM_ENABLE_UPPER_OFS, 16'hFFFF);
        reg_rd(ALARM_ENABLE_UPPER_OFS, 16'h0103);
        for (int i = 0; i < 3; i++) begin
            data_t want;
            want = (i == 2) ? 16'h0100 : 16'h0001 << i;
            raise(3'h1 << i, '0, 1'b0);
            compare("alarm_out", data_t'(alarm_out_q), 16'h0001);
            compare("irq", data_t'(irq_q), 16'h0001);
            reg_rd(ALARM_REASON_UPPER_OFS, want);
            reg_rd(ALARM_REASON_UPPER_OFS, 16'h0000);
            reg_rd(IRQ_STATUS_OFS, 16'h0001);
            tick(2);
            compare("alarm_out", data_t'(alarm_out_q), 16'h0000);
            compare("irq", data_t'(irq_q), 16'h0000);
        end
        reg_wr(IRQ_MASK_OFS, 16'h0000);
        raise(3'h4, '0, 1'b0);
        compare("irq", data_t'(irq_q), 16'h0000);
        reg_rd(ALARM_REASON_UPPER_OFS, 16'h0100);
        reg_rd(IRQ_STATUS_OFS, 16'h0001);
        reg_wr(ALARM_ENABLE_UPPER_OFS, 16'h0000);
        raise(3'h7, '0, 1'b0);
        compare("alarm_out", data_t'(alarm_out_q), 16'h0000);
        reg_rd(ALARM_REASON_UPPER_OFS, 16'h0000);
        // rise lands on the very edge that takes the clearing read
        reg_wr(ALARM_ENABLE_UPPER_OFS, 16'h0100);
        @(posedge core_clk);
        req <= '{addr: ALARM_REASON_UPPER_OFS, wdata: '0, wr: 1'b0, rd: 1'b1};
        alarm_ev <= 3'h4;
        @(posedge core_clk);
        req.rd <= 1'b0;
        alarm_ev <= '0;
        #1;
        compare("rdata", rdata_q, 16'h0000);
        reg_rd(ALARM_REASON_UPPER_OFS, 16'h0100);
        for (int i = 0; i < 15; i++) begin
            reg_wr(WAKE_ENABLE_LOWER_OFS, data_t'(1) << i);
            reg_wr(SLEEP_CTRL_OFS, 16'h0001);
            compare("awake", data_t'(awake_q), 16'h0000);
            raise('0, 15'h1 << ((i + 1) % 15), 1'b0);
            compare("awake", data_t'(awake_q), 16'h0000);
            raise('0, 15'h1 << i, 1'b0);
            compare("awake", data_t'(awake_q), 16'h0001);
            reg_rd(WAKE_REASON_LOWER_OFS, data_t'(1) << i);
        end
        compare("frames", data_t'(frames), 16'h0000);
        reg_wr(WAKE_ENABLE_LOWER_OFS, 16'hC000);
        reg_wr(SLEEP_CTRL_OFS, 16'h0001);
        reg_rd(SLEEP_CTRL_OFS, 16'h0001);
        raise('0, 15'h4000, 1'b0);
        compare("frames", data_t'(frames), 16'h0001);
        reg_rd(WAKE_REASON_LOWER_OFS, 16'h4000);
        reg_rd(IRQ_STATUS_OFS, 16'h0007);
        reg_wr(WAKE_ENABLE_LOWER_OFS, 16'h8000);
        reg_wr(SLEEP_CTRL_OFS, 16'h0001);
        raise('0, '0, 1'b1);
        compare("awake", data_t'(awake_q), 16'h0001);
        compare("frames", data_t'(frames), 16'h0001);
        reg_rd(WAKE_REASON_LOWER_OFS, 16'h8000);
        reg_rd(WAKE_REASON_LOWER_OFS, 16'h0000);
        reg_rd(IRQ_STATUS_OFS, 16'h0002);
        @(posedge core_clk);
        wake_ev <= 15'h4001;
        reg_rd(EVENT_LEVEL_OFS, 16'h4001);
        @(posedge core_clk);
        wake_ev <= '0;
        results();
    end
endmodule

`default_nettype wire
